// File: rtl/pfc_fault_classifier.sv
// Fault classifier for untranslated requests with a process-space ID
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module pfc_fault_classifier
  import pfc_pkg::*;
#(
  parameter int PTS_BASE = 5,
  parameter bit EXEC_SUPPORTED = 1'b1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and walk results from the translation pipeline
  input wire logic req_valid,
  output logic req_ready,
  input wire pfc_req_s req,
  input wire pfc_walk_s walk,
  // Classification result
  output logic res_valid,
  output pfc_res_s res,
  output logic res_fault,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt
  output logic irq
);

  // Software state
  logic root_table_type_flag;
  logic exec_sw_enable;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] mask;
  logic [CODE_W-1:0] last_code;
  logic last_qual;
  logic [31:0] fault_count;

  // Bus slave state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic [EV_W-1:0] status_clr;

  // Classification
  logic exec_active;
  logic [PASID_W:0] pasid_limit;
  logic canon_ok;
  logic sl_perm;
  logic exec_miss;
  logic [CODE_W-1:0] next_code;
  logic next_qual;
  logic hit;
  logic [EV_W-1:0] ev;

  // Classifier never stalls
  // Every check settles within one cycle, so no back-pressure
  assign req_ready = 1'b1;

  // Execute bit is meaningful only if built in and turned on
  // Otherwise a stray execute bit must neither grant nor fault
  assign exec_active = EXEC_SUPPORTED & exec_sw_enable;

  // Largest ID allowed by the table-size field, plus one
  // One bit wider than the ID so the largest size cannot wrap to zero
  assign pasid_limit = (PASID_W + 1)'(1) <<
      (walk.ctx.id_table_size_field + PTS_BASE[PASID_W:0]);

  // Bits 63:48 must all copy bit 47
  // Checked on the raw request address, after the context and ID-table checks, ahead of the first-level walk results
  assign canon_ok = (req.addr[CANON_HI:CANON_LO] ==
      {(CANON_HI - CANON_LO + 1){req.addr[CANON_SIGN]}});

  // Missing execute permission on the walked path
  always_comb begin
    exec_miss = 1'b0;
    // First level: any used entry on the path with execute disabled
    for (int i = 0; i < LEVELS; i++) begin
      if (walk.fl[i].used && walk.fl[i].exec_dis) begin
        exec_miss = 1'b1;
      end
    end
    // Final page of the nested second level
    if (walk.ctx.nested && walk.sl[0].used && exec_active && !walk.sl[0].ex) begin
      exec_miss = 1'b1;
    end
  end

  // Priority walk: the first failing check decides the code
  always_comb begin
    // Defaults: no fault, not qualified
    next_code = FR_NONE;
    next_qual = 1'b0;
    sl_perm = 1'b0;
    // Wrong root table type: nothing below it can be trusted
    if (!root_table_type_flag) begin
      next_code = FR_ROOT_TYPE;
      next_qual = 1'b0;
    end else if (walk.ctx.present && (walk.ctx.rsvd != '0)) begin
      // Context-entry checks; only a present entry is examined
      next_code = FR_CTX_RSVD;
    end else if (walk.ctx.present && !walk.ctx.process_space_id_enable) begin
      next_code = FR_NO_PASID_EN;
    end else if (walk.ctx.present && ({1'b0, req.pasid} >= pasid_limit)) begin
      next_code = FR_PASID_RANGE;
    end else if (walk.ctx.present && req.exec_req && !walk.ctx.execute_request_enable) begin
      // Request flags against the context enables, still at context level
      next_code = FR_EXEC_REQ_OFF;
      next_qual = 1'b1;
    end else if (walk.ctx.present && req.priv_req &&
        !walk.ctx.supervisor_request_enable) begin
      next_code = FR_SUPV_REQ_OFF;
      next_qual = 1'b1;
    end else if (!walk.pe.present) begin
      // ID-table entry checks
      next_code = FR_PE_ABSENT;
    end else if (walk.pe.rsvd != '0) begin
      next_code = FR_PE_RSVD;
    end else if (!canon_ok) begin
      // Address shape, then the fetch of the top first-level entry
      next_code = FR_NONCANON;
    end else if (walk.fl_top_fetch_err) begin
      next_code = FR_FL_TOP_FETCH;
      next_qual = 1'b1;
    end else begin
      // First-level walk from the top entry down; stop at first fault
      for (int i = LEVELS - 1; i >= 0; i--) begin
        // Levels the walk did not reach are skipped
        if (next_code == FR_NONE && walk.fl[i].used) begin
          // A nested fault hides the fetch error that it caused
          if (walk.ctx.nested && walk.nest_fault[i] &&
              walk.nest_code >= FR_NEST_LO && walk.nest_code <= FR_NEST_HI) begin
            next_code = walk.nest_code;
            next_qual = 1'b1;
          end else if (i < LEVELS - 1 && walk.fl_fetch_err[i]) begin
            // The top level has its own fetch code
            next_code = FR_FL_FETCH;
            next_qual = 1'b1;
          end else if (walk.fl[i].present && (walk.fl[i].rsvd != '0)) begin
            next_code = FR_FL_RSVD;
            next_qual = 1'b1;
          end
        end
      end
      // Second-level entries for the final page
      for (int i = LEVELS - 1; i >= 0; i--) begin
        // Permission bits decide whether reserved bits count at all
        sl_perm = walk.sl[i].rd | walk.sl[i].wr | (walk.sl[i].ex & exec_active);
        if (next_code == FR_NONE && walk.sl[i].used && sl_perm &&
            (walk.sl[i].rsvd != '0)) begin
          next_code = FR_SL_RSVD;
        end
      end
      // Execute denial last, once the whole walk is clean
      if (next_code == FR_NONE && req.is_read && req.exec_req && exec_miss) begin
        next_code = FR_EXEC_DENY;
        next_qual = 1'b1;
      end
    end
  end

  // Fault only when a request is really present this cycle
  assign hit = req_valid && (next_code != FR_NONE);

  // Result register, one cycle after the request
  // Code and flags hold until the next request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_valid <= 1'b0;
      res <= '0;
      res_fault <= 1'b0;
    end else begin
      // Pulses follow the request by one cycle
      res_valid <= req_valid;
      res_fault <= hit;
      if (req_valid) begin
        res.code <= next_code;
        res.qualified <= next_qual;
        res.unsupported <= (next_code != FR_NONE);
      end
    end
  end

  // Last fault and fault counter
  // Last fault is what software reads after the interrupt
  // Counter wraps at the top; software works with differences
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_code <= FR_NONE;
      last_qual <= 1'b0;
      fault_count <= '0;
    end else if (hit) begin
      last_code <= next_code;
      last_qual <= next_qual;
      fault_count <= fault_count + 32'h0000_0001;
    end
  end

  // Events for the interrupt status
  // One event per class, all raised with the result
  assign ev[EV_ANY] = hit;
  assign ev[EV_QUAL] = hit & next_qual;
  assign ev[EV_NONQUAL] = hit & ~next_qual;

  // Write channel acceptance, address and data in either order
  // Each half is refused while held or while a response waits
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  // Write address capture
  // Address kept until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  // Write data capture
  // Data and strobes kept until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Both halves held: perform the write
  assign wr_fire = aw_held && w_held;
  // Known offsets; read-only ones answer OKAY and keep their value
  assign wr_ok = (aw_addr == REG_CTRL) || (aw_addr == REG_STATUS) || (aw_addr == REG_MASK) ||
      (aw_addr == REG_LAST) || (aw_addr == REG_COUNT);

  // Write response
  // Response stands until the master is ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register
  // Root table type clears at reset, so every request faults until set
  // Only byte 0 carries fields, so only its strobe matters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      root_table_type_flag <= 1'b0;
      exec_sw_enable <= 1'b0;
    end else if (wr_fire && aw_addr == REG_CTRL && w_strb[0]) begin
      root_table_type_flag <= w_data[CTRL_RTT_BIT];
      exec_sw_enable <= w_data[CTRL_XEN_BIT];
    end
  end

  // Mask register
  // Mask bits match the status layout
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= '0;
    end else if (wr_fire && aw_addr == REG_MASK && w_strb[0]) begin
      mask <= w_data[EV_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear
  assign status_clr = (wr_fire && aw_addr == REG_STATUS && w_strb[0]) ?
      w_data[EV_W-1:0] : '0;

  // Status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      status <= (status & ~status_clr) | ev;
    end
  end

  // Level interrupt from unmasked status
  assign irq = |(status & mask);

  // Read channel: answer one cycle after the address is taken
  // Address is taken only while no read data waits
  // Unmapped offsets answer SLVERR with zero data
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: begin
          s_axi_rdata <= '0;
          s_axi_rdata[CTRL_RTT_BIT] <= root_table_type_flag;
          s_axi_rdata[CTRL_XEN_BIT] <= exec_sw_enable;
        end
        REG_STATUS: s_axi_rdata <= {{(32 - EV_W){1'b0}}, status};
        REG_MASK: s_axi_rdata <= {{(32 - EV_W){1'b0}}, mask};
        REG_LAST: begin
          // Code in the low byte, class flag above it
          s_axi_rdata <= {24'h000000, last_code};
          s_axi_rdata[LAST_QUAL_BIT] <= last_qual;
        end
        REG_COUNT: s_axi_rdata <= fault_count;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// File: rtl/pfc_pkg.sv
// Package: types, register map and fault reason codes for the classifier
package pfc_pkg;

  localparam int PASID_W = 20;
  localparam int ADDR_W = 64;
  localparam int RSVD_W = 64;
  localparam int LEVELS = 4;
  localparam int CODE_W = 8;

  // Fault reason codes
  localparam logic [CODE_W-1:0] FR_NONE = 8'h00;
  localparam logic [CODE_W-1:0] FR_CTX_RSVD = 8'h0b;
  localparam logic [CODE_W-1:0] FR_SL_RSVD = 8'h0c;
  localparam logic [CODE_W-1:0] FR_NO_PASID_EN = 8'h10;
  localparam logic [CODE_W-1:0] FR_PASID_RANGE = 8'h11;
  localparam logic [CODE_W-1:0] FR_PE_ABSENT = 8'h12;
  localparam logic [CODE_W-1:0] FR_PE_RSVD = 8'h13;
  localparam logic [CODE_W-1:0] FR_NONCANON = 8'h14;
  localparam logic [CODE_W-1:0] FR_FL_TOP_FETCH = 8'h15;
  localparam logic [CODE_W-1:0] FR_FL_RSVD = 8'h16;
  localparam logic [CODE_W-1:0] FR_FL_FETCH = 8'h17;
  localparam logic [CODE_W-1:0] FR_EXEC_DENY = 8'h18;
  localparam logic [CODE_W-1:0] FR_EXEC_REQ_OFF = 8'h19;
  localparam logic [CODE_W-1:0] FR_SUPV_REQ_OFF = 8'h1a;
  localparam logic [CODE_W-1:0] FR_ROOT_TYPE = 8'h1b;
  localparam logic [CODE_W-1:0] FR_NEST_LO = 8'h04;
  localparam logic [CODE_W-1:0] FR_NEST_HI = 8'h06;

  // Canonical address check bounds
  localparam int CANON_HI = 63;
  localparam int CANON_LO = 48;
  localparam int CANON_SIGN = 47;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_LAST = 8'h0c;
  localparam logic [7:0] REG_COUNT = 8'h10;

  // Field positions and widths
  localparam int CTRL_RTT_BIT = 0;
  localparam int CTRL_XEN_BIT = 1;
  localparam int EV_W = 3;
  localparam int EV_ANY = 0;
  localparam int EV_QUAL = 1;
  localparam int EV_NONQUAL = 2;
  localparam int LAST_QUAL_BIT = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [PASID_W-1:0] pasid;
    logic [ADDR_W-1:0] addr;
    logic exec_req;        // execute_requested_flag
    logic priv_req;        // privileged_mode_flag
    logic is_read;
  } pfc_req_s;

  typedef struct packed {
    logic present;
    logic process_space_id_enable;
    logic [2:0] id_table_size_field;
    logic execute_request_enable;
    logic supervisor_request_enable;
    logic nested;
    logic [RSVD_W-1:0] rsvd;
  } pfc_ctx_s;

  typedef struct packed {
    logic present;
    logic [RSVD_W-1:0] rsvd;
  } pfc_pe_s;

  typedef struct packed {
    logic used;
    logic present;
    logic exec_dis;
    logic [RSVD_W-1:0] rsvd;
  } pfc_fl_s;

  typedef struct packed {
    logic used;
    logic rd;
    logic wr;
    logic ex;
    logic [RSVD_W-1:0] rsvd;
  } pfc_sl_s;

  typedef struct packed {
    pfc_ctx_s ctx;
    pfc_pe_s pe;
    pfc_fl_s [LEVELS-1:0] fl;
    pfc_sl_s [LEVELS-1:0] sl;
    logic fl_top_fetch_err;
    logic [LEVELS-1:0] fl_fetch_err;
    logic [LEVELS-1:0] nest_fault;
    logic [CODE_W-1:0] nest_code;
  } pfc_walk_s;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic qualified;
    logic unsupported;
  } pfc_res_s;

endpackage

// File: verif/pfc_fault_classifier_properties.sv
// Checker of result timing and fault flags of the classifier
`timescale 1ns/1ps
module pfc_checker
  import pfc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and result
  input wire logic req_valid,
  input wire logic res_valid,
  input wire pfc_res_s res,
  input wire logic res_fault
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // One result a cycle after each request, none otherwise
  a_res_next: assert property (req_valid |=> res_valid) else $error("no result");
  a_res_only: assert property (!req_valid |=> !res_valid) else $error("stray result");
  a_res_held: assert property (!req_valid |=> $stable(res)) else $error("result moved");
  // Fault flag and class follow the code
  a_fault_flag: assert property (res_valid |-> res_fault == (res.code != FR_NONE))
    else $error("fault flag wrong");
  a_fault_pulse: assert property (res_fault |-> res_valid) else $error("fault without result");
  a_fault_unsup: assert property (res_fault |-> res.unsupported) else $error("not refused");
  a_top_qual: assert property (res_valid && res.code == FR_FL_TOP_FETCH |-> res.qualified)
    else $error("top fetch not qualified");
  a_root_nonqual: assert property (res_valid && res.code == FR_ROOT_TYPE |-> !res.qualified)
    else $error("root type qualified");
  // Main scenarios
  c_fault: cover property (res_fault);
  c_clean: cover property (res_valid && !res_fault);
  c_nest: cover property (res_valid && res.code == 8'h05);
endmodule

bind pfc_fault_classifier pfc_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .req_valid(req_valid), .res_valid(res_valid), .res(res), .res_fault(res_fault));

// File: verif/pfc_endpoint.sv
// Endpoint model issuing requests with their walk results
`timescale 1ns/1ps
module pfc_endpoint
  import pfc_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Request towards the classifier
  output logic req_valid,
  output pfc_req_s req,
  output pfc_walk_s walk
);
  // Idle at time zero
  initial begin
    req_valid = 1'b0;
    req = '0;
    walk = '0;
  end
  // One request; payload inverted once released
  task automatic send(input pfc_req_s r, input pfc_walk_s w);
    @(posedge aclk);
    req_valid <= 1'b1;
    req <= r;
    walk <= w;
    @(posedge aclk);
    req_valid <= 1'b0;
    req <= ~r;
    walk <= ~w;
  endtask
endmodule

// File: verif/pfc_fault_classifier_tb.sv
// Self-checking bench for the fault classifier
`timescale 1ns/1ps
module pfc_fault_classifier_tb
  import pfc_pkg::*;
;
  logic aclk, aresetn, req_valid, req_ready, res_valid, res_fault, irq;
  pfc_req_s req;
  pfc_walk_s walk;
  pfc_res_s res;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_errors, n_compared, nf;
  pfc_fault_classifier #(.PTS_BASE(5), .EXEC_SUPPORTED(1'b1)) dut_u (.aclk(aclk),
    .aresetn(aresetn), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .walk(walk), .res_valid(res_valid), .res(res), .res_fault(res_fault),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq));
  pfc_endpoint ep_u (.aclk(aclk), .req_valid(req_valid), .req(req), .walk(walk));
  // Clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bus write; each channel released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(negedge aclk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  // Bus read
  task automatic axi_rd(input logic [7:0] a);
    logic ar_ok, r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ar_ok = arvalid & arready;
      r_ok = rvalid;
      d = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // One request and its result
  task automatic req_chk(input pfc_req_s r, input pfc_walk_s w, input logic [7:0] c);
    ep_u.send(r, w);
    #1;
    if (c != FR_NONE) nf++;
    chk("res_valid", 32'h1, res_valid);
    chk("req_ready", 32'h1, req_ready);
    chk("code", c, res.code);
    chk("fault", c != FR_NONE, res_fault);
    chk("qualified", (c >= 8'h04 && c <= 8'h06) || (c >= 8'h15 && c <= 8'h1a),
      res.qualified);
    chk("unsupported", c != FR_NONE, res.unsupported);
  endtask
  // Clean walk altered for case i
  task automatic mk(input int i, output pfc_req_s r, output pfc_walk_s w, output logic [7:0] c);
    r = '0;
    r.pasid = 20'h1f;
    r.is_read = 1'b1;
    w = '0;
    w.ctx = '{1'b1, 1'b1, 3'h0, 1'b1, 1'b1, 1'b0, 64'h0};
    w.pe.present = 1'b1;
    for (int k = 0; k < LEVELS; k++) w.fl[k] = '{1'b1, 1'b1, 1'b0, 64'h0};
    c = FR_NONE;
    case (i)
      1: begin w.ctx.rsvd = 64'h1; w.pe.present = 1'b0; c = FR_CTX_RSVD; end
      2: begin w.ctx.process_space_id_enable = 1'b0; c = FR_NO_PASID_EN; end
      3: begin r.pasid = 20'h20; c = FR_PASID_RANGE; end
      4: begin r.exec_req = 1'b1; w.ctx.execute_request_enable = 1'b0;
        c = FR_EXEC_REQ_OFF; end
      5: begin r.priv_req = 1'b1; w.ctx.supervisor_request_enable = 1'b0;
        c = FR_SUPV_REQ_OFF; end
      6: begin w.pe.present = 1'b0; c = FR_PE_ABSENT; end
      7: begin w.pe.rsvd = 64'h8000_0000_0000_0000; c = FR_PE_RSVD; end
      8: begin r.addr = 64'h0001_0000_0000_0000; c = FR_NONCANON; end
      9: begin w.fl_top_fetch_err = 1'b1; c = FR_FL_TOP_FETCH; end
      10: begin w.fl[1].rsvd = 64'h4; c = FR_FL_RSVD; end
      11: begin w.fl_fetch_err[1] = 1'b1; c = FR_FL_FETCH; end
      12: begin w.ctx.nested = 1'b1; w.nest_fault[2] = 1'b1; w.nest_code = 8'h05;
        w.fl_fetch_err[2] = 1'b1; c = 8'h05; end
      13: begin w.sl[2] = '{1'b1, 1'b0, 1'b1, 1'b0, 64'h2}; c = FR_SL_RSVD; end
      14: begin w.sl[0] = '{1'b1, 1'b0, 1'b0, 1'b1, 64'h1}; c = FR_SL_RSVD; end
      15: begin r.exec_req = 1'b1; w.fl[0].exec_dis = 1'b1; c = FR_EXEC_DENY; end
      16: r.addr = 64'hffff_8000_0000_0000;
      17: begin w.ctx.nested = 1'b1; r.exec_req = 1'b1;
        w.sl[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 64'h0}; c = FR_EXEC_DENY; end
      default: c = FR_NONE;
    endcase
  endtask
  task automatic t_codes();
    pfc_req_s r;
    pfc_walk_s w;
    logic [7:0] c;
    mk(0, r, w, c);
    req_chk(r, w, FR_ROOT_TYPE);
    axi_wr(REG_CTRL, 32'h3);
    for (int i = 0; i <= 17; i++) begin
      mk(i, r, w, c);
      req_chk(r, w, c);
    end
    axi_wr(REG_CTRL, 32'h1);
    mk(14, r, w, c);
    req_chk(r, w, FR_NONE);
    $display("test codes done");
  endtask
  task automatic t_regs();
    pfc_req_s r;
    pfc_walk_s w;
    logic [7:0] c;
    axi_wr(REG_STATUS, 32'h7);
    axi_wr(REG_MASK, 32'h0);
    mk(6, r, w, c);
    req_chk(r, w, c);
    chk("irq masked", 32'h0, irq);
    axi_rd(REG_STATUS);
    chk("status", 32'h5, d);
    axi_wr(REG_MASK, 32'h1);
    #1;
    chk("irq", 32'h1, irq);
    axi_rd(REG_LAST);
    chk("last", 32'h12, d);
    axi_wr(REG_STATUS, 32'h1);
    #1;
    chk("irq cleared", 32'h0, irq);
    axi_rd(REG_STATUS);
    chk("status w1c", 32'h4, d);
    axi_wr(REG_COUNT, 32'h0);
    chk("ro write resp", RESP_OKAY, rsp);
    axi_rd(REG_COUNT);
    chk("count", nf, d);
    axi_rd(8'h20);
    chk("unmapped resp", RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, d);
    axi_wr(8'h24, 32'h1);
    chk("unmapped wr resp", RESP_SLVERR, rsp);
    $display("test registers done");
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  // Reset, then the scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(REG_CTRL);
    chk("ctrl reset", 32'h0, d);
    t_codes();
    t_regs();
    end_of_test();
  end
endmodule
